/* src/flash_prot_pkg.sv */
// Shared constants and enumerations for the flash protection block
package flash_prot_pkg;

	localparam int          FLASH_BYTES = 262144;        // Whole array
	localparam int          BLOCK_BYTES = 1024;          // Erase block
	localparam int          UNIT_BYTES  = 2048;          // Protection unit
	localparam int          ADDR_W      = 18;            // Byte address width
	localparam int          WORD_W      = 32;
	localparam int          WORDS       = FLASH_BYTES / 4;
	localparam int          BLOCK_WORDS = BLOCK_BYTES / 4;
	localparam int          UNITS       = FLASH_BYTES / UNIT_BYTES;
	localparam int          BLK_LSB     = 10;            // Block number field
	localparam int          UNIT_LSB    = 11;            // Unit number field
	localparam logic [7:0]  LAST_WORD   = 8'hFF;         // Last word in a block
	localparam logic [31:0] ERASED_WORD = 32'hFFFF_FFFF;
	localparam logic [31:0] DENY_WORD   = 32'h0000_0000; // Returned on a denied read

	typedef enum logic [1:0] {
		SRC_FETCH = 2'b00,
		SRC_DATA  = 2'b01,
		SRC_DEBUG = 2'b10
	} src_e;

	typedef enum logic [1:0] {
		OP_READ  = 2'b00,
		OP_PROG  = 2'b01,
		OP_ERASE = 2'b10
	} op_e;

	typedef enum logic [0:0] {
		ST_IDLE  = 1'b0,
		ST_ERASE = 1'b1
	} state_e;

endpackage : flash_prot_pkg

/* src/flash_prot_check.sv */
// Permission decision for one request against one protection unit
`timescale 1ns/1ps
module flash_prot_check (
	input  wire logic [1:0] src,     // Requester
	input  wire logic [1:0] op,      // Operation
	input  wire logic       unit_ro, // Unit marked read-only
	input  wire logic       unit_xo, // Unit marked execute-only
	output logic            allow    // Request may proceed
);

	// Writes need an unmarked unit, reads need fetch when execute-only
	always_comb begin
		allow = 1'b0;
		case (op)
			flash_prot_pkg::OP_READ: begin
				allow = !unit_xo || (src == flash_prot_pkg::SRC_FETCH);
			end
			flash_prot_pkg::OP_PROG,
			flash_prot_pkg::OP_ERASE: begin
				allow = !unit_ro && !unit_xo;
			end
			default: begin
				allow = 1'b0;
			end
		endcase
	end

endmodule : flash_prot_check

/* src/flash_block_protection.sv */
// Flash array with per-unit read-only and execute-only protection
//
// Contract
// - 256 KB array, 1 KB blocks erased separately
// - Erase leaves every block bit at one
// - Protection per 2 KB pair of blocks
// - Units marked read-only or execute-only
// - Read-only units refuse erase and program
// - Execute-only units refuse erase and program
// - Execute-only units readable by instruction fetch only
`timescale 1ns/1ps
module flash_block_protection (
	input  wire logic                                core_clk,  // System clock, 10 MHz
	input  wire logic                                rstn,      // Async reset, active low
	input  wire logic [flash_prot_pkg::UNITS-1:0]    prot_ro,   // Read-only mark per unit
	input  wire logic [flash_prot_pkg::UNITS-1:0]    prot_xo,   // Execute-only mark per unit
	input  wire logic                                req_valid, // Request present
	input  wire logic [1:0]                          req_src,   // Fetch, data or debug
	input  wire logic [1:0]                          req_op,    // Read, program or erase
	input  wire logic [flash_prot_pkg::ADDR_W-1:0]   req_addr,  // Byte address
	input  wire logic [flash_prot_pkg::WORD_W-1:0]   req_wdata, // Program data
	output logic                                     req_ready, // Request accepted when high
	output logic                                     rsp_valid, // One-cycle answer
	output logic [flash_prot_pkg::WORD_W-1:0]        rsp_rdata, // Read data
	output logic                                     rsp_fault  // Request refused
);

	logic                                 rst_meta;
	logic                                 rst_n;
	logic [flash_prot_pkg::WORD_W-1:0]    mem [flash_prot_pkg::WORDS];
	flash_prot_pkg::state_e               state;
	logic [7:0]                           erase_cnt;
	logic [7:0]                           erase_blk;
	logic [15:0]                          erase_word;
	logic [15:0]                          req_word;
	logic [6:0]                           req_unit;
	logic                                 allow;
	logic                                 accept;

	// Reset release through two flops
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// Address fields
	assign req_word   = req_addr[flash_prot_pkg::ADDR_W-1:2];
	assign req_unit   = req_addr[flash_prot_pkg::ADDR_W-1:flash_prot_pkg::UNIT_LSB];
	assign erase_word = {erase_blk, erase_cnt};
	assign accept     = req_valid && req_ready;

	// Both blocks of a pair share one unit's marks
	flash_prot_check u_check (
		.src     (req_src),
		.op      (req_op),
		.unit_ro (prot_ro[req_unit]),
		.unit_xo (prot_xo[req_unit]),
		.allow   (allow)
	);

	// Array contents; erase walks one word per cycle
	always_ff @(posedge core_clk) begin
		if (state == flash_prot_pkg::ST_ERASE) begin
			mem[erase_word] <= flash_prot_pkg::ERASED_WORD;
		end else if (accept && allow && req_op == flash_prot_pkg::OP_PROG) begin
			mem[req_word] <= mem[req_word] & req_wdata; // Programming only clears bits
		end
	end

	// Erase sequencer and ready
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state     <= flash_prot_pkg::ST_IDLE;
			erase_cnt <= 8'h00;
			erase_blk <= 8'h00;
			req_ready <= 1'b0;
		end else begin
			case (state)
				flash_prot_pkg::ST_IDLE: begin
					req_ready <= 1'b1;
					if (accept && allow && req_op == flash_prot_pkg::OP_ERASE) begin
						state     <= flash_prot_pkg::ST_ERASE;
						erase_blk <= req_addr[flash_prot_pkg::ADDR_W-1:flash_prot_pkg::BLK_LSB];
						erase_cnt <= 8'h00;
						req_ready <= 1'b0;
					end
				end
				flash_prot_pkg::ST_ERASE: begin
					erase_cnt <= erase_cnt + 8'h01;
					if (erase_cnt == flash_prot_pkg::LAST_WORD) begin
						state     <= flash_prot_pkg::ST_IDLE;
						req_ready <= 1'b1;
					end
				end
				default: begin
					state <= flash_prot_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Answers: reads and programs next cycle, erase at its end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rsp_valid <= 1'b0;
			rsp_fault <= 1'b0;
			rsp_rdata <= flash_prot_pkg::DENY_WORD;
		end else begin
			rsp_valid <= 1'b0;
			if (state == flash_prot_pkg::ST_ERASE) begin
				if (erase_cnt == flash_prot_pkg::LAST_WORD) begin
					rsp_valid <= 1'b1;
					rsp_fault <= 1'b0;
				end
			end else if (accept) begin
				rsp_valid <= !(allow && req_op == flash_prot_pkg::OP_ERASE);
				rsp_fault <= !allow;
				if (allow && req_op == flash_prot_pkg::OP_READ) begin
					rsp_rdata <= mem[req_word];
				end else begin
					rsp_rdata <= flash_prot_pkg::DENY_WORD;
				end
			end
		end
	end

	// Erase answer delay, counted from the taken edge
	localparam int ERASE_WAIT = flash_prot_pkg::BLOCK_WORDS + 1;

	// Refused writes answer next cycle with a fault
	property p_ro_refuse;
		@(posedge core_clk) disable iff (!rst_n)
		accept && prot_ro[req_unit] && (req_op == flash_prot_pkg::OP_PROG
			|| req_op == flash_prot_pkg::OP_ERASE)
		|=> rsp_valid && rsp_fault && req_ready;
	endproperty
	a_ro_refuse: assert property (p_ro_refuse) else $error("read-only write not refused");

	property p_xo_refuse;
		@(posedge core_clk) disable iff (!rst_n)
		accept && prot_xo[req_unit] && req_op != flash_prot_pkg::OP_READ
		|=> rsp_valid && rsp_fault;
	endproperty
	a_xo_refuse: assert property (p_xo_refuse) else $error("exec-only write not refused");

	property p_xo_fetch;
		@(posedge core_clk) disable iff (!rst_n)
		accept && prot_xo[req_unit] && req_op == flash_prot_pkg::OP_READ
			&& req_src == flash_prot_pkg::SRC_FETCH
		|=> rsp_valid && !rsp_fault && rsp_rdata == mem[$past(req_word)];
	endproperty
	a_xo_fetch: assert property (p_xo_fetch) else $error("fetch of exec-only unit failed");

	property p_xo_deny;
		@(posedge core_clk) disable iff (!rst_n)
		accept && prot_xo[req_unit] && req_op == flash_prot_pkg::OP_READ
			&& req_src != flash_prot_pkg::SRC_FETCH
		|=> rsp_valid && rsp_fault && rsp_rdata == flash_prot_pkg::DENY_WORD;
	endproperty
	a_xo_deny: assert property (p_xo_deny) else $error("exec-only data read not denied");

	property p_read_data;
		@(posedge core_clk) disable iff (!rst_n)
		accept && !prot_xo[req_unit] && req_op == flash_prot_pkg::OP_READ
		|=> rsp_valid && !rsp_fault && rsp_rdata == mem[$past(req_word)];
	endproperty
	a_read_data: assert property (p_read_data) else $error("open read returned wrong data");

	property p_erase_len;
		@(posedge core_clk) disable iff (!rst_n)
		accept && allow && req_op == flash_prot_pkg::OP_ERASE
		|=> !rsp_valid [*8] ##[1:ERASE_WAIT] rsp_valid && !rsp_fault;
	endproperty
	a_erase_len: assert property (p_erase_len) else $error("erase answer missing");

	property p_erase_ones;
		@(posedge core_clk) disable iff (!rst_n)
		state == flash_prot_pkg::ST_ERASE |=> mem[$past(erase_word)] == flash_prot_pkg::ERASED_WORD;
	endproperty
	a_erase_ones: assert property (p_erase_ones) else $error("erased word not all ones");

	property p_pair_same;
		@(posedge core_clk) disable iff (!rst_n)
		state == flash_prot_pkg::ST_ERASE
		|-> !req_ready && (erase_blk[7:1] == $past(erase_blk[7:1]) || $past(accept));
	endproperty
	a_pair_same: assert property (p_pair_same) else $error("ready high during erase");

	// Erase answer lands once the last word is written
	property p_erase_exact;
		@(posedge core_clk) disable iff (!rst_n)
		accept && allow && req_op == flash_prot_pkg::OP_ERASE
		|-> ##ERASE_WAIT rsp_valid && !rsp_fault && req_ready;
	endproperty
	a_erase_exact: assert property (p_erase_exact) else $error("erase answer not on time");

	// Every refused answer carries the fixed word
	property p_refuse_word;
		@(posedge core_clk) disable iff (!rst_n)
		rsp_valid && rsp_fault |-> rsp_rdata == flash_prot_pkg::DENY_WORD;
	endproperty
	a_refuse_word: assert property (p_refuse_word) else $error("refused answer carries data");

	// Erase of a marked unit never starts the sequencer
	property p_refused_idle;
		@(posedge core_clk) disable iff (!rst_n)
		accept && (prot_ro[req_unit] || prot_xo[req_unit])
			&& req_op == flash_prot_pkg::OP_ERASE
		|=> state == flash_prot_pkg::ST_IDLE && req_ready;
	endproperty
	a_refused_idle: assert property (p_refused_idle) else $error("marked unit erased");

	// Program of a marked unit leaves the stored word
	property p_ro_keep;
		@(posedge core_clk) disable iff (!rst_n)
		accept && (prot_ro[req_unit] || prot_xo[req_unit])
			&& req_op == flash_prot_pkg::OP_PROG
		|=> mem[$past(req_word)] == $past(mem[req_word]);
	endproperty
	a_ro_keep: assert property (p_ro_keep) else $error("marked word was programmed");

	// Main scenarios reached
	c_erase_done: cover property (@(posedge core_clk) disable iff (!rst_n)
		state == flash_prot_pkg::ST_ERASE ##1 state == flash_prot_pkg::ST_IDLE);
	c_deny_read: cover property (@(posedge core_clk) disable iff (!rst_n)
		rsp_valid && rsp_fault && rsp_rdata == flash_prot_pkg::DENY_WORD);
	c_fetch_xo: cover property (@(posedge core_clk) disable iff (!rst_n)
		accept && prot_xo[req_unit] && req_src == flash_prot_pkg::SRC_FETCH);
	c_ro_erase: cover property (@(posedge core_clk) disable iff (!rst_n)
		accept && prot_ro[req_unit] && req_op == flash_prot_pkg::OP_ERASE);

endmodule : flash_block_protection

/* verification/flash_requester.sv */
// Requester model standing in for fetch, data and debug masters
`timescale 1ns/1ps
module flash_requester (
	input  wire logic        core_clk,  // System clock
	input  wire logic        req_ready, // Request accepted
	input  wire logic        rsp_valid, // Answer strobe
	input  wire logic [31:0] rsp_rdata, // Answer data
	input  wire logic        rsp_fault, // Answer refused
	output logic             req_valid, // Request present
	output logic      [1:0]  req_src,   // Requester kind
	output logic      [1:0]  req_op,    // Operation
	output logic      [17:0] req_addr,  // Byte address
	output logic      [31:0] req_wdata  // Program data
);
	int lat; // Edges from acceptance to answer

	initial begin
		{req_valid, req_src, req_op, req_addr, req_wdata} = '0;
	end

	// Hold request until taken, then release and scramble the bus
	task automatic send(input logic [1:0] s, input logic [1:0] o, input logic [17:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic f);
		int n;
		n = 0;
		@(posedge core_clk);
		req_valid <= 1'b1;
		req_src   <= s;
		req_op    <= o;
		req_addr  <= a;
		req_wdata <= d;
		do @(posedge core_clk); while (req_ready !== 1'b1);
		req_valid <= 1'b0;
		req_addr  <= ~a;
		req_wdata <= ~d;
		do begin
			@(posedge core_clk);
			n++;
		end while (rsp_valid !== 1'b1 && n < 400);
		lat = n;
		q = rsp_rdata;
		f = (rsp_valid === 1'b1) ? rsp_fault : 1'bx;
	endtask : send
endmodule : flash_requester

/* verification/test_flash_block_protection.sv */
// Self-checking bench for the flash protection block
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fail_count++; \
	$display("unexpected at %0t: got %h want %h", $time, a, b); end end
module test_flash_block_protection;
	logic         core_clk, rstn, req_ready, rsp_valid, rsp_fault, req_valid, f;
	logic [127:0] prot_ro, prot_xo;
	logic [1:0]   req_src, req_op;
	logic [17:0]  req_addr;
	logic [31:0]  req_wdata, rsp_rdata, q;
	int           fail_count, checks_done;

	flash_block_protection u_dut (.core_clk, .rstn, .prot_ro, .prot_xo, .req_valid,
		.req_src, .req_op, .req_addr, .req_wdata, .req_ready, .rsp_valid, .rsp_rdata,
		.rsp_fault);
	flash_requester u_req (.core_clk, .req_ready, .rsp_valid, .rsp_rdata, .rsp_fault,
		.req_valid, .req_src, .req_op, .req_addr, .req_wdata);

	// One transfer through the requester model
	task automatic xfer(input logic [1:0] s, input logic [1:0] o, input logic [17:0] a,
		input logic [31:0] d);
		u_req.send(s, o, a, d, q, f);
	endtask : xfer

	// Erase both blocks of unit 0, check erased state at block edges
	task automatic t_erase;
		xfer(2'b01, 2'b10, 18'h0_0000, 32'h0);
		`CHK(f, 1'b0)
		`CHK(u_req.lat, flash_prot_pkg::BLOCK_WORDS + 1)
		`CHK(req_ready, 1'b1)
		fork
			xfer(2'b01, 2'b10, 18'h0_0400, 32'h0);
			begin
				repeat (100) @(posedge core_clk);
				`CHK(req_ready, 1'b0)
			end
		join
		`CHK(f, 1'b0)
		xfer(2'b01, 2'b00, 18'h0_0000, 32'h0);
		`CHK({f, q}, {1'b0, 32'hFFFF_FFFF})
		xfer(2'b10, 2'b00, 18'h0_07FC, 32'h0);
		`CHK({f, q}, {1'b0, 32'hFFFF_FFFF})
	endtask : t_erase

	// Program twice, undefined op refused, erase neighbour block, data survives
	task automatic t_prog;
		xfer(2'b01, 2'b01, 18'h0_0404, 32'h1234_5678);
		`CHK(f, 1'b0)
		xfer(2'b01, 2'b01, 18'h0_0404, 32'hFF00_FF00);
		xfer(2'b01, 2'b11, 18'h0_0404, 32'h0);
		`CHK(f, 1'b1)
		xfer(2'b01, 2'b10, 18'h0_0000, 32'h0);
		xfer(2'b01, 2'b00, 18'h0_0404, 32'h0);
		`CHK({f, q}, {1'b0, 32'h1200_5600})
	endtask : t_prog

	// Read-only unit refuses writes, still readable, neighbour unit free
	task automatic t_ro;
		@(posedge core_clk) prot_ro <= 128'h1;
		xfer(2'b01, 2'b01, 18'h0_0404, 32'h0);
		`CHK(f, 1'b1)
		xfer(2'b01, 2'b10, 18'h0_0400, 32'h0);
		`CHK(f, 1'b1)
		xfer(2'b10, 2'b00, 18'h0_0404, 32'h0);
		`CHK({f, q}, {1'b0, 32'h1200_5600})
		xfer(2'b01, 2'b10, 18'h0_0800, 32'h0);
		`CHK(f, 1'b0)
		@(posedge core_clk) prot_ro <= '0;
	endtask : t_ro

	// Execute-only unit serves fetch only and refuses writes
	task automatic t_xo;
		@(posedge core_clk) prot_xo <= 128'h1;
		xfer(2'b00, 2'b00, 18'h0_0404, 32'h0);
		`CHK({f, q}, {1'b0, 32'h1200_5600})
		xfer(2'b01, 2'b00, 18'h0_0404, 32'h0);
		`CHK({f, q}, {1'b1, flash_prot_pkg::DENY_WORD})
		xfer(2'b10, 2'b00, 18'h0_0404, 32'h0);
		`CHK({f, q}, {1'b1, flash_prot_pkg::DENY_WORD})
		xfer(2'b01, 2'b01, 18'h0_0404, 32'h0);
		`CHK(f, 1'b1)
		xfer(2'b01, 2'b10, 18'h0_0000, 32'h0);
		`CHK(f, 1'b1)
		@(posedge core_clk) prot_xo <= '0;
		xfer(2'b01, 2'b00, 18'h0_0404, 32'h0);
		`CHK({f, q}, {1'b0, 32'h1200_5600})
	endtask : t_xo

	// Verdict and end of run
	task automatic finish_test;
		if (fail_count == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : finish_test

	// Clock
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	// Watchdog
	initial begin
		#3_000_000;
		fail_count++;
		finish_test;
	end

	// Main sequence
	initial begin
		rstn    = 1'b0;
		prot_ro = '0;
		prot_xo = '0;
		repeat (6) @(posedge core_clk);
		rstn <= 1'b1;
		t_erase;
		t_prog;
		t_ro;
		t_xo;
		finish_test;
	end
endmodule : test_flash_block_protection
